// ===== rtl/interval_timer_consts.vh
`ifndef INTERVAL_TIMER_CONSTS_VH
`define INTERVAL_TIMER_CONSTS_VH

// register byte addresses on the plain register port
`define ADDR_W 16
`define ADDR_CTRL 16'hff37
`define ADDR_CLKSEL 16'hff3a
`define ADDR_COUNT 16'hff30
`define ADDR_CMP0 16'hff32
`define ADDR_CMP1 16'hff34

// control register field positions
`define CTRL_CE 3
`define CTRL_CLR1 1
`define CTRL_CLR0 0
`define CTRL_MASK 8'h0b
`define CLKSEL_MASK 8'h07

// reset values
`define CTRL_RST 8'h00
`define CLKSEL_RST 8'h00
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define COUNT_MAX 16'hffff
`define CMP_RST 16'h0000

// shared time base: 64 is the longest division
`define TB_W 6
`define TB_ZERO 6'h00
`define SEL_DIV4 3'h0
`define SEL_DIV8 3'h1
`define SEL_DIV16 3'h2
`define SEL_DIV32 3'h3
`define SEL_DIV64 3'h4
`define TB_ONE 6'h01

// time base taps: a tap fires when all of its low bits are ones
`define TAP_DIV4 6'h03
`define TAP_DIV8 6'h07
`define TAP_DIV16 6'h0f
`define TAP_DIV32 6'h1f
`define TAP_DIV64 6'h3f

// field widths
`define SEL_W 3
`define BYTE_W 8
`define WORD_W 16
`define BYTE_ZERO 8'h00

`endif

// ===== rtl/dual_compare_interval_timer.v
// Overview of operation
// - 16-bit counter increments once per selected count clock while enabled.
// - clock select codes 0..4 give system clock divided by 4,8,16,32,64.
// - each compare register raises its own match pulse when counter equals it.
// - enabling from zero loads 0001H on the first following count clock.
// - disabling clears counter to 0000H at once and stops matches.
// - writing enable one while already one does not clear the counter.
// - count clock at FFFFH wraps to 0000H and raises overflow pulse.
// - control bit 3 is count enable, bits 1 and 0 clear-on-match enables.
// - clear-on-match keeps matched value until the next count clock.
// - re-enable after clear-by-disable gives value 1 on next count clock.
// - matches are evaluated only on increments, never on compare writes.
// - compare value 0000H matches only after wrapping through FFFFH or after a clear-on-match.
// - match coinciding with disable still raises its match pulse.
// - first compare match pulse also drives the real-time output trigger.
// - reset clears control, select, counter and both compare registers.
// - counter is read-only as a word; compare registers are read/write words.
// - first count clock after enabling may come early by less than one count period.
// - interval mode with compare n repeats matches every n+1 count clocks.
//
// Strobed register access was left to the implementer.
`include "interval_timer_consts.vh"

module dual_compare_interval_timer (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // event pulses
  output reg match_irq_zero,
  output reg match_irq_one,
  output reg overflow_irq,
  output reg rto_trigger
);

  ////////////////////////////////////////////////////////////////////////////
  // software-visible registers
  reg [`BYTE_W-1:0] timer_control_r;
  reg [`BYTE_W-1:0] timer_control_nxt;
  reg [`BYTE_W-1:0] count_clock_select_r;
  reg [`BYTE_W-1:0] count_clock_select_nxt;
  reg [`WORD_W-1:0] count_value_r;
  reg [`WORD_W-1:0] count_nxt;
  reg [`WORD_W-1:0] compare_value_zero_r;
  reg [`WORD_W-1:0] compare_value_zero_nxt;
  reg [`WORD_W-1:0] compare_value_one_r;
  reg [`WORD_W-1:0] compare_value_one_nxt;

  // shared time base and its tap
  reg [`TB_W-1:0] time_base_r;
  reg [`TB_W-1:0] time_base_nxt;
  reg [`TB_W-1:0] tap_mask;

  // start and clear bookkeeping
  reg fresh_start_r;
  reg fresh_start_nxt;
  reg clear_pend_r;
  reg clear_pend_nxt;
  reg [`WORD_W-1:0] count_step;
  reg [`WORD_W-1:0] count_land;

  // event pulse next values
  reg match_zero_nxt;
  reg match_one_nxt;
  reg overflow_nxt;
  reg trigger_nxt;

  // read path
  reg [`WORD_W-1:0] rdata_nxt;

  // register port decode
  wire wr_ctrl;
  wire wr_clksel;
  wire wr_cmp0;
  wire wr_cmp1;
  wire rd_ctrl;
  wire rd_clksel;
  wire rd_count;
  wire rd_cmp0;
  wire rd_cmp1;

  // control fields and requests
  wire ce_now;
  wire ce_new;
  wire clr0_en;
  wire clr1_en;
  wire start_req;
  wire stop_req;

  // count clock and compare results
  wire tick_sel;
  wire count_tick;
  wire hit_zero;
  wire hit_one;
  wire clear_req;
  wire wrap_now;

  ////////////////////////////////////////////////////////////////////////////
  // true when the register port addresses the given register
  function addr_hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // a match is true only when the counter steps onto the compare value
  function cmp_hit;
    input [`WORD_W-1:0] value;
    input [`WORD_W-1:0] cmp;
    begin
      cmp_hit = (value == cmp);
    end
  endfunction

  // tap mask of a clock select code; prohibited codes get an empty mask
  function [`TB_W-1:0] tap_of;
    input [`SEL_W-1:0] sel;
    begin
      case (sel)
        `SEL_DIV4: tap_of = `TAP_DIV4;
        `SEL_DIV8: tap_of = `TAP_DIV8;
        `SEL_DIV16: tap_of = `TAP_DIV16;
        `SEL_DIV32: tap_of = `TAP_DIV32;
        `SEL_DIV64: tap_of = `TAP_DIV64;
        default: tap_of = `TB_ZERO;
      endcase
    end
  endfunction

  // byte register placed on the word-wide read bus, upper byte zero
  function [`WORD_W-1:0] byte_to_word;
    input [`BYTE_W-1:0] value;
    begin
      byte_to_word = {`BYTE_ZERO, value};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write decode; the count register has no write decode at all
  assign wr_ctrl = reg_wr && addr_hit(reg_addr, `ADDR_CTRL);
  assign wr_clksel = reg_wr && addr_hit(reg_addr, `ADDR_CLKSEL);
  assign wr_cmp0 = reg_wr && addr_hit(reg_addr, `ADDR_CMP0);
  assign wr_cmp1 = reg_wr && addr_hit(reg_addr, `ADDR_CMP1);

  // read decode
  assign rd_ctrl = reg_rd && addr_hit(reg_addr, `ADDR_CTRL);
  assign rd_clksel = reg_rd && addr_hit(reg_addr, `ADDR_CLKSEL);
  assign rd_count = reg_rd && addr_hit(reg_addr, `ADDR_COUNT);
  assign rd_cmp0 = reg_rd && addr_hit(reg_addr, `ADDR_CMP0);
  assign rd_cmp1 = reg_rd && addr_hit(reg_addr, `ADDR_CMP1);

  // control fields; a start is only a zero-to-one change of the enable
  assign ce_now = timer_control_r[`CTRL_CE];
  assign ce_new = reg_wdata[`CTRL_CE];
  assign clr0_en = timer_control_r[`CTRL_CLR0];
  assign clr1_en = timer_control_r[`CTRL_CLR1];
  assign stop_req = wr_ctrl && !ce_new;
  assign start_req = wr_ctrl && ce_new && !ce_now;

  ////////////////////////////////////////////////////////////////////////////
  // shared time base: free running, so the first tick after enable may be short
  always @*
  begin
    time_base_nxt = time_base_r + `TB_ONE;
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      time_base_r <= `TB_ZERO;
    else
      time_base_r <= time_base_nxt;
  end

  // tap select from the clock select code
  always @*
  begin
    tap_mask = tap_of(count_clock_select_r[`SEL_W-1:0]);
  end

  // one-cycle count pulse, only while enabled; an empty mask never ticks
  assign tick_sel = (tap_mask != `TB_ZERO) && ((time_base_r & tap_mask) == tap_mask);
  assign count_tick = tick_sel && ce_now;

  ////////////////////////////////////////////////////////////////////////////
  // value the next tick lands on: 0001H after a start, 0000H after a clear
  always @*
  begin
    count_step = count_value_r + `COUNT_ONE;
    if (fresh_start_r)
      count_land = `COUNT_ONE;
    else if (clear_pend_r)
      count_land = `COUNT_ZERO;
    else
      count_land = count_step;
  end

  // counter next value; a disable clears at once, ahead of any tick
  always @*
  begin
    count_nxt = count_value_r;
    if (stop_req)
      count_nxt = `COUNT_ZERO;
    else if (count_tick)
      count_nxt = count_land;
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_value_r <= `COUNT_ZERO;
    else
      count_value_r <= count_nxt;
  end

  // compares look at the stepped value only, so a compare write equal to
  // the counter never fires, and 0000H needs a wrap or a clear to match
  assign hit_zero = count_tick && cmp_hit(count_land, compare_value_zero_r);
  assign hit_one = count_tick && cmp_hit(count_land, compare_value_one_r);
  assign clear_req = (clr0_en && hit_zero) || (clr1_en && hit_one);
  assign wrap_now = count_tick && !fresh_start_r && !clear_pend_r && (count_value_r == `COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // start flag: the first tick after a start loads 0001H, not the next count
  always @*
  begin
    fresh_start_nxt = fresh_start_r;
    if (stop_req)
      fresh_start_nxt = 1'b0;
    else if (start_req)
      fresh_start_nxt = 1'b1;
    else if (count_tick)
      fresh_start_nxt = 1'b0;
  end

  // clear-on-match waits for the next tick, so the matched value stays visible;
  // a match on the very first tick after a start clears as well
  always @*
  begin
    clear_pend_nxt = clear_pend_r;
    if (stop_req)
      clear_pend_nxt = 1'b0;
    else if (count_tick)
      clear_pend_nxt = clear_req;
  end

  // a pending clear is dropped on disable, since the counter is zero already
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fresh_start_r <= 1'b0;
      clear_pend_r <= 1'b0;
    end
    else
    begin
      fresh_start_r <= fresh_start_nxt;
      clear_pend_r <= clear_pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event pulses: the tick is taken before a same-cycle disable lands,
  // so a match coinciding with a stop still raises its request
  always @*
  begin
    match_zero_nxt = hit_zero;
    match_one_nxt = hit_one;
    trigger_nxt = hit_zero;
    overflow_nxt = wrap_now;
  end

  // match pulses last one cycle; the interrupt controller keeps the flags
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      match_irq_zero <= 1'b0;
      match_irq_one <= 1'b0;
    end
    else
    begin
      match_irq_zero <= match_zero_nxt;
      match_irq_one <= match_one_nxt;
    end
  end

  // overflow and output trigger, also one cycle each
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      overflow_irq <= 1'b0;
      rto_trigger <= 1'b0;
    end
    else
    begin
      overflow_irq <= overflow_nxt;
      rto_trigger <= trigger_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: only the enable and the two clear bits are kept
  always @*
  begin
    timer_control_nxt = timer_control_r;
    if (wr_ctrl)
      timer_control_nxt = reg_wdata[`BYTE_W-1:0] & `CTRL_MASK;
  end

  // clock select: changing it while running may give one odd tick
  always @*
  begin
    count_clock_select_nxt = count_clock_select_r;
    if (wr_clksel)
      count_clock_select_nxt = reg_wdata[`BYTE_W-1:0] & `CLKSEL_MASK;
  end

  // compare registers are plain words; the counter itself is read-only
  always @*
  begin
    compare_value_zero_nxt = compare_value_zero_r;
    if (wr_cmp0)
      compare_value_zero_nxt = reg_wdata;
  end

  always @*
  begin
    compare_value_one_nxt = compare_value_one_r;
    if (wr_cmp1)
      compare_value_one_nxt = reg_wdata;
  end

  // compares get a defined reset value so simulation shows no unknowns
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_control_r <= `CTRL_RST;
      count_clock_select_r <= `CLKSEL_RST;
      compare_value_zero_r <= `CMP_RST;
      compare_value_one_r <= `CMP_RST;
    end
    else
    begin
      timer_control_r <= timer_control_nxt;
      count_clock_select_r <= count_clock_select_nxt;
      compare_value_zero_r <= compare_value_zero_nxt;
      compare_value_one_r <= compare_value_one_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses and idle cycles read zero
  always @*
  begin
    rdata_nxt = `COUNT_ZERO;
    if (rd_ctrl)
      rdata_nxt = byte_to_word(timer_control_r);
    else if (rd_clksel)
      rdata_nxt = byte_to_word(count_clock_select_r);
    else if (rd_count)
      rdata_nxt = count_value_r;
    else if (rd_cmp0)
      rdata_nxt = compare_value_zero_r;
    else if (rd_cmp1)
      rdata_nxt = compare_value_one_r;
  end

  // read data stand one cycle after the strobe and are zero otherwise
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= `COUNT_ZERO;
    else
      reg_rdata <= rdata_nxt;
  end

endmodule // dual_compare_interval_timer

// ===== verif/timer_checker_asserts.sv
`include "interval_timer_consts.vh"
module timer_checker (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // event pulses
  input wire match_irq_zero,
  input wire match_irq_one,
  input wire overflow_irq,
  input wire rto_trigger
);
  logic [7:0] ctl_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // control shadow, so reads and the stopped state can be judged
  always_ff @(posedge core_clk or posedge rst)
    if (rst) ctl_r <= 8'h00;
    else if (reg_wr && reg_addr == `ADDR_CTRL) ctl_r <= reg_wdata[7:0] & 8'h0b;
  a_rto_equal: assert property (rto_trigger == match_irq_zero)
    else $error("trigger differs");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("stray data");
  a_ctl_read: assert property (reg_rd && reg_addr == `ADDR_CTRL |=> reg_rdata == {8'h00, $past(ctl_r)})
    else $error("control read");
  a_stop_count: assert property (reg_rd && reg_addr == `ADDR_COUNT && !ctl_r[3] |=> reg_rdata == 16'h0000)
    else $error("stopped count");
  a_stop_quiet: assert property (reg_wr && reg_addr == `ADDR_CTRL && !reg_wdata[3] |-> ##2 !match_irq_one)
    else $error("match after stop");
  a_zero_gap: assert property (match_irq_zero |=> !match_irq_zero [*3])
    else $error("match zero gap");
  a_one_gap: assert property (match_irq_one |=> !match_irq_one [*3])
    else $error("match one gap");
  a_wrap_gap: assert property (overflow_irq |=> !overflow_irq [*3])
    else $error("overflow gap");
  c_zero: cover property (match_irq_zero);
  c_one: cover property (match_irq_one);
  c_count: cover property (reg_rd && reg_addr == `ADDR_COUNT);
endmodule // timer_checker
bind dual_compare_interval_timer timer_checker chk (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .match_irq_zero, .match_irq_one, .overflow_irq, .rto_trigger);

// ===== verif/irq_sink.sv
module irq_sink (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // requests: trigger, overflow, match one, match zero
  input wire [3:0] req,
  // latched request tallies
  output logic [3:0][7:0] tally
);
  timeunit 1ns;
  timeprecision 1ps;
  // a one-cycle pulse is one latched request, so it counts once
  always_ff @(posedge core_clk or posedge rst)
    if (rst) tally <= '0;
    else for (int i = 0; i < 4; i++) tally[i] <= tally[i] + {7'h00, req[i]};
endmodule // irq_sink

// ===== verif/tb.sv
`include "interval_timer_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  logic match_irq_zero, match_irq_one, overflow_irq, rto_trigger;
  logic [3:0][7:0] tally;
  int errors, checks_done, cyc;
  dual_compare_interval_timer DUT (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .match_irq_zero, .match_irq_one, .overflow_irq, .rto_trigger);
  irq_sink far_end (.core_clk, .rst, .req({rto_trigger, overflow_irq, match_irq_one, match_irq_zero}), .tally);
  initial forever #5 core_clk = ~core_clk;
  // cycle count; a hang ends the run
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000) results();
  end
  task automatic cmp(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // bus cycles: strobes last one cycle, data sampled when settled
  task automatic wr(input logic [15:0] a, d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, e, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp(nm, e, reg_rdata);
  endtask
  // waits for one more request of kind k, bounded
  task automatic hit(input int k);
    logic [7:0] t;
    int w;
    t = tally[k];
    for (w = 0; w < 300 && tally[k] === t; w++) @(negedge core_clk);
    cmp("request", 16'h0001, 16'(w < 300));
  endtask
  // the first interval may be short, so the second one is measured
  task automatic gap(input int k, e);
    int t0;
    hit(k);
    t0 = cyc;
    hit(k);
    cmp("interval", 16'(e), 16'(cyc - t0));
  endtask
  task automatic t_regs();
    rd(`ADDR_CTRL, 16'h0000, "control");
    rd(`ADDR_CLKSEL, 16'h0000, "select");
    wr(`ADDR_COUNT, 16'h1234);
    rd(`ADDR_COUNT, 16'h0000, "count");
    wr(`ADDR_CTRL, 16'h00f7);
    rd(`ADDR_CTRL, 16'h0003, "control");
    wr(`ADDR_CMP0, 16'h5a3c);
    rd(`ADDR_CMP0, 16'h5a3c, "compare");
    rd(16'hff00, 16'h0000, "unmapped");
    $display("registers done");
  endtask
  task automatic t_div();
    for (int c = 0; c < 5; c++)
    begin
      wr(`ADDR_CTRL, 16'h0000);
      wr(`ADDR_CLKSEL, 16'(c));
      wr(`ADDR_CMP1, 16'h0001);
      wr(`ADDR_CTRL, 16'h000a);
      gap(1, 8 << c);
    end
    $display("dividers done");
  endtask
  task automatic t_cmp0();
    logic [7:0] m1;
    wr(`ADDR_CTRL, 16'h0000);
    wr(`ADDR_CLKSEL, 16'h0000);
    wr(`ADDR_CMP0, 16'h0003);
    wr(`ADDR_CMP1, 16'h0100);
    m1 = tally[1];
    wr(`ADDR_CTRL, 16'h0009);
    gap(0, 16);
    cmp("trigger", {8'h00, tally[0]}, {8'h00, tally[3]});
    cmp("match one", {8'h00, m1}, {8'h00, tally[1]});
    $display("clear on match done");
  endtask
  task automatic t_restart();
    logic [7:0] m0;
    wr(`ADDR_CTRL, 16'h0000);
    rd(`ADDR_COUNT, 16'h0000, "stopped");
    wr(`ADDR_CMP1, 16'h0001);
    wr(`ADDR_CMP0, 16'h0000);
    m0 = tally[0];
    wr(`ADDR_CTRL, 16'h0008);
    hit(1);
    rd(`ADDR_COUNT, 16'h0001, "first");
    wr(`ADDR_CTRL, 16'h0008);
    rd(`ADDR_COUNT, 16'h0002, "running");
    cmp("zero compare", {8'h00, m0}, {8'h00, tally[0]});
    $display("restart done");
  endtask
  // free running: each handler moves compare zero on by four counts
  task automatic t_free();
    int t0;
    wr(`ADDR_CTRL, 16'h0000);
    wr(`ADDR_CMP0, 16'h0004);
    wr(`ADDR_CTRL, 16'h0008);
    hit(0);
    for (int s = 2; s < 4; s++)
    begin
      t0 = cyc;
      wr(`ADDR_CMP0, 16'(4 * s));
      hit(0);
      cmp("step", 16'h0010, 16'(cyc - t0));
    end
    cmp("overflow", 16'h0000, {8'h00, tally[2]});
    $display("free running done");
  endtask
  task automatic results();
    if (cyc >= 20000) errors++;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_div();
    t_cmp0();
    t_restart();
    t_free();
    results();
  end
endmodule // tb
